/* File: core/usart_cfg_consts.svh */
`ifndef USART_CFG_CONSTS_SVH
`define USART_CFG_CONSTS_SVH

//----------------------------------------
// Register map
//----------------------------------------
`define SERIAL_CONTROL_FIRST_OFFSET  12'h000
`define SYNC_BUSY_FLAGS_OFFSET       12'h01C
`define SERIAL_CONTROL_FIRST_RESET   32'h0000_0000
`define SERIAL_CONTROL_FIRST_WMASK   32'h7FF3_E09F
`define SERIAL_CONTROL_FIRST_EPMASK  32'h7FF3_E09C

//----------------------------------------
// Field positions
//----------------------------------------
`define SW_RESET_POS         0
`define ENABLE_POS           1
`define OP_MODE_LSB          2
`define OP_MODE_MSB          4
`define OVERSAMPLE_RATE_LSB  13
`define OVERSAMPLE_RATE_MSB  15
`define TRANSMIT_PAD_LSB     16
`define TRANSMIT_PAD_MSB     17
`define RECEIVE_PAD_LSB      20
`define RECEIVE_PAD_MSB      21
`define SAMPLE_TICK_LSB      22
`define SAMPLE_TICK_MSB      23
`define FRAME_FORMAT_LSB     24
`define FRAME_FORMAT_MSB     27
`define SYNC_ASYNC_POS       28
`define CLOCK_EDGE_POS       29
`define BIT_ORDER_POS        30
`define RESERVED_TOP_POS     31
`define ENABLE_BUSY_POS      1

//----------------------------------------
// Oversampling
//----------------------------------------
`define TICKS_16X   5'h10
`define TICKS_8X    5'h08
`define TICKS_3X    5'h03
`define WINDOW_16X  5'h07
`define WINDOW_8X   5'h03
`define WINDOW_3X   5'h01

//----------------------------------------
// Fixed pads
//----------------------------------------
`define HANDSHAKE_OUT_PAD  2'h2
`define HANDSHAKE_IN_PAD   2'h3

`endif

/* File: core/usart_cfg_pkg.sv */
package usart_cfg_pkg;

	typedef enum logic [2:0] {
		FS_IDLE   = 3'h0,
		FS_START  = 3'h1,
		FS_DATA   = 3'h2,
		FS_PARITY = 3'h3,
		FS_STOP   = 3'h4
	} frame_state_t;

	typedef enum logic [2:0] {
		RATE_16X_ARITH = 3'h0,
		RATE_16X_FRAC  = 3'h1,
		RATE_8X_ARITH  = 3'h2,
		RATE_8X_FRAC   = 3'h3,
		RATE_3X_ARITH  = 3'h4
	} rate_t;

	typedef enum logic [1:0] {
		TXPAD_D0_X1 = 2'h0,
		TXPAD_D2_X3 = 2'h1,
		TXPAD_D0_HS = 2'h2,
		TXPAD_RSVD  = 2'h3
	} tx_pad_t;

	typedef enum logic [2:0] {
		OPMODE_EXT_CLK = 3'h0,
		OPMODE_INT_CLK = 3'h1
	} op_mode_t;

endpackage : usart_cfg_pkg

/* File: core/usart_control_a_config.sv */
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "usart_cfg_consts.svh"

// Contract
// - Accept 8, 16, 32-bit indivisible accesses
// - Each byte and half writable alone
// - Protected fields ignore writes while enabled
// - Write guard may block control writes
// - Top bit reads zero, write zero
// - Bit order: clear MSB first, set LSB
// - Polarity picks change and sample edges
// - Mode bit: clear async, set sync
// - Frame code bit 0 selects parity, other bits unused
// - Adjust field picks three voted ticks at 16x and 8x
// - Receive data taken from selected pad
// - Transmit pad code routes data, clock, handshake
// - Rate field picks oversampling factor
// - Config fields apply without sync delay
// - Operating mode picks external or internal clock
// - Enable reads back at once, busy flag
module usart_control_a_config (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Access controller
	input  wire logic        peripheral_write_guard,
	// Serial link
	input  wire logic        link_clk,
	input  wire logic [3:0]  pad_in,
	output logic      [3:0]  pad_out,
	output logic      [3:0]  pad_oe,
	// Character stream, link clock domain
	input  wire logic        tx_valid,
	input  wire logic [7:0]  tx_data,
	output logic             tx_ready,
	output logic      [7:0]  rx_data,
	output logic             rx_valid,
	output logic             rx_parity_err,
	output logic             rx_frame_err
);

	//----------------------------------------
	// APB decode
	//----------------------------------------
	logic [31:0] serial_control_first_r;
	logic [31:0] serial_control_first_nxt;
	logic        ack_p1_r;
	logic        ack_p2_r;

	wire         access_pend = psel && penable && !pready;
	wire         xfer_done   = psel && penable && pready;
	wire         hit_ctrl    = (paddr == `SERIAL_CONTROL_FIRST_OFFSET);
	wire         hit_busy    = (paddr == `SYNC_BUSY_FLAGS_OFFSET);
	wire         enabled_sw  = serial_control_first_r[`ENABLE_POS];
	wire         enable_busy = enabled_sw ^ ack_p2_r;
	wire [31:0]  strb_mask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [31:0]  prot_mask   = enabled_sw ? `SERIAL_CONTROL_FIRST_EPMASK : 32'h0000_0000;
	wire [31:0]  wr_mask     = strb_mask & `SERIAL_CONTROL_FIRST_WMASK & ~prot_mask;
	wire [31:0]  wr_value    = (serial_control_first_r & ~wr_mask) | (pwdata & wr_mask);
	wire         ctrl_wr     = xfer_done && pwrite && hit_ctrl && !peripheral_write_guard;
	wire         swrst_wr    = ctrl_wr && pstrb[0] && pwdata[`SW_RESET_POS];
	wire         guard_hit   = pwrite && hit_ctrl && peripheral_write_guard;
	wire [31:0]  busy_word   = {{30{1'b0}}, enable_busy, 1'b0};
	wire [31:0]  read_mux    = hit_ctrl ? (serial_control_first_r & `SERIAL_CONTROL_FIRST_WMASK) :
	                           hit_busy ? busy_word : 32'h0000_0000;
	wire         bus_error   = !(hit_ctrl || hit_busy) || guard_hit;

	// Software reset wins over the rest of the same write
	always_comb begin
		serial_control_first_nxt = serial_control_first_r;
		if (swrst_wr)
			serial_control_first_nxt = `SERIAL_CONTROL_FIRST_RESET;
		else if (ctrl_wr)
			serial_control_first_nxt = {1'b0, wr_value[30:1], 1'b0};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_control_first_r <= `SERIAL_CONTROL_FIRST_RESET;
			pready                 <= 1'b0;
			pslverr                <= 1'b0;
			prdata                 <= 32'h0000_0000;
		end else begin
			serial_control_first_r <= serial_control_first_nxt;
			pready                 <= access_pend;
			pslverr                <= access_pend && bus_error;
			if (access_pend)
				prdata <= read_mux;
		end
	end

	//----------------------------------------
	// Enable crossing
	//----------------------------------------
	logic lrst1_r;
	logic lrst2_r;
	logic en_l1_r;
	logic en_l2_r;
	wire  lrst_n = lrst2_r;

	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			lrst1_r <= 1'b0;
			lrst2_r <= 1'b0;
		end else begin
			lrst1_r <= 1'b1;
			lrst2_r <= lrst1_r;
		end
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			en_l1_r <= 1'b0;
			en_l2_r <= 1'b0;
		end else begin
			en_l1_r <= enabled_sw;
			en_l2_r <= en_l1_r;
		end
	end

	// Busy until the link domain echoes the enable level back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_p1_r <= 1'b0;
			ack_p2_r <= 1'b0;
		end else begin
			ack_p1_r <= en_l2_r;
			ack_p2_r <= ack_p1_r;
		end
	end

	//----------------------------------------
	// Configuration, static while enabled
	//----------------------------------------
	wire       bit_order_select       = serial_control_first_r[`BIT_ORDER_POS];
	wire       clock_edge_polarity    = serial_control_first_r[`CLOCK_EDGE_POS];
	wire       sync_async_select      = serial_control_first_r[`SYNC_ASYNC_POS];
	wire [3:0] frame_format           = serial_control_first_r[`FRAME_FORMAT_MSB:`FRAME_FORMAT_LSB];
	wire [1:0] sample_tick_adjust     = serial_control_first_r[`SAMPLE_TICK_MSB:`SAMPLE_TICK_LSB];
	wire [1:0] receive_pad_select     = serial_control_first_r[`RECEIVE_PAD_MSB:`RECEIVE_PAD_LSB];
	wire [1:0] transmit_pad_select    = serial_control_first_r[`TRANSMIT_PAD_MSB:`TRANSMIT_PAD_LSB];
	wire [2:0] oversample_rate_select = serial_control_first_r[`OVERSAMPLE_RATE_MSB:`OVERSAMPLE_RATE_LSB];
	wire [2:0] op_mode                = serial_control_first_r[`OP_MODE_MSB:`OP_MODE_LSB];

	wire       internal_clk = (op_mode == usart_cfg_pkg::OPMODE_INT_CLK);
	wire       parity_on    = frame_format[0];
	wire       rate_8x      = (oversample_rate_select == usart_cfg_pkg::RATE_8X_ARITH) ||
	                          (oversample_rate_select == usart_cfg_pkg::RATE_8X_FRAC);
	wire       rate_3x      = (oversample_rate_select == usart_cfg_pkg::RATE_3X_ARITH);
	wire [4:0] bit_ticks    = rate_3x ? `TICKS_3X : rate_8x ? `TICKS_8X : `TICKS_16X;
	wire [4:0] win_lo       = rate_3x ? `WINDOW_3X :
	                          rate_8x ? (`WINDOW_8X + {3'h0, sample_tick_adjust}) :
	                          (`WINDOW_16X + {2'h0, sample_tick_adjust, 1'b0});
	wire [4:0] win_hi       = win_lo + 5'h02;
	wire       hs_mode      = (transmit_pad_select == usart_cfg_pkg::TXPAD_D0_HS);
	wire       tx_pad_ok    = (transmit_pad_select != usart_cfg_pkg::TXPAD_RSVD);
	wire [1:0] tx_pad       = (transmit_pad_select == usart_cfg_pkg::TXPAD_D2_X3) ? 2'h2 : 2'h0;
	wire [1:0] xck_pad      = (transmit_pad_select == usart_cfg_pkg::TXPAD_D2_X3) ? 2'h3 : 2'h1;
	wire       xck_used     = sync_async_select && !hs_mode && tx_pad_ok;

	//----------------------------------------
	// Link pads and serial clock
	//----------------------------------------
	logic [3:0] pad_s1_r;
	logic [3:0] pad_s2_r;
	logic       xck_int_r;
	logic       xck_prev_r;
	logic       txd_r;

	wire rxd        = pad_s2_r[receive_pad_select];
	wire xck_level  = internal_clk ? xck_int_r : pad_s2_r[xck_pad];
	wire xck_rise   = xck_level && !xck_prev_r;
	wire xck_fall   = !xck_level && xck_prev_r;
	wire edge_chg   = clock_edge_polarity ? xck_fall : xck_rise;
	wire edge_smp   = clock_edge_polarity ? xck_rise : xck_fall;
	wire cts_ok     = !hs_mode || !pad_s2_r[`HANDSHAKE_IN_PAD];
	wire rts_level  = !en_l2_r;

	logic [3:0] pad_out_nxt;
	logic [3:0] pad_oe_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_pad
			wire is_tx  = tx_pad_ok && (tx_pad == 2'(gi));
			wire is_xck = xck_used && internal_clk && (xck_pad == 2'(gi));
			wire is_rts = hs_mode && (`HANDSHAKE_OUT_PAD == 2'(gi));
			assign pad_oe_nxt[gi]  = en_l2_r && (is_tx || is_xck || is_rts);
			assign pad_out_nxt[gi] = is_tx ? txd_r : is_xck ? xck_int_r : is_rts ? rts_level : 1'b1;
		end
	endgenerate

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			pad_s1_r   <= 4'hF;
			pad_s2_r   <= 4'hF;
			xck_int_r  <= 1'b0;
			xck_prev_r <= 1'b0;
			pad_out    <= 4'hF;
			pad_oe     <= 4'h0;
		end else begin
			pad_s1_r   <= pad_in;
			pad_s2_r   <= pad_s1_r;
			xck_int_r  <= (en_l2_r && xck_used && internal_clk) ? !xck_int_r : 1'b0;
			xck_prev_r <= xck_level;
			pad_out    <= pad_out_nxt;
			pad_oe     <= pad_oe_nxt;
		end
	end

	//----------------------------------------
	// Transmitter
	//----------------------------------------
	usart_cfg_pkg::frame_state_t tx_st_r;
	logic [7:0] tx_sh_r;
	logic       tx_par_r;
	logic [2:0] tx_cnt_r;
	logic [4:0] tx_tick_r;

	wire       tx_go      = tx_valid && tx_ready;
	wire       tx_step    = sync_async_select ? edge_chg : (tx_tick_r == bit_ticks - 5'h01);
	wire [7:0] tx_sh_next = bit_order_select ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};
	wire       tx_first   = bit_order_select ? tx_data[0] : tx_data[7];
	wire       tx_bit     = bit_order_select ? tx_sh_next[0] : tx_sh_next[7];

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			tx_st_r   <= usart_cfg_pkg::FS_IDLE;
			tx_sh_r   <= 8'h00;
			tx_par_r  <= 1'b0;
			tx_cnt_r  <= 3'h0;
			tx_tick_r <= 5'h00;
			txd_r     <= 1'b1;
			tx_ready  <= 1'b0;
		end else if (!en_l2_r) begin
			tx_st_r   <= usart_cfg_pkg::FS_IDLE;
			tx_tick_r <= 5'h00;
			txd_r     <= 1'b1;
			tx_ready  <= 1'b0;
		end else begin
			tx_ready  <= (tx_st_r == usart_cfg_pkg::FS_IDLE) && !tx_go && cts_ok;
			tx_tick_r <= (tx_st_r == usart_cfg_pkg::FS_IDLE || tx_step) ? 5'h00 : tx_tick_r + 5'h01;
			case (tx_st_r)
				usart_cfg_pkg::FS_IDLE: begin
					if (tx_go) begin
						tx_sh_r  <= tx_data;
						tx_par_r <= ^tx_data;
						tx_st_r  <= usart_cfg_pkg::FS_START;
						txd_r    <= 1'b0;
					end
				end
				usart_cfg_pkg::FS_START: begin
					if (tx_step) begin
						tx_st_r  <= usart_cfg_pkg::FS_DATA;
						tx_cnt_r <= 3'h0;
						txd_r    <= bit_order_select ? tx_sh_r[0] : tx_sh_r[7];
					end
				end
				usart_cfg_pkg::FS_DATA: begin
					if (tx_step) begin
						tx_sh_r  <= tx_sh_next;
						tx_cnt_r <= tx_cnt_r + 3'h1;
						if (tx_cnt_r == 3'h7) begin
							tx_st_r <= parity_on ? usart_cfg_pkg::FS_PARITY : usart_cfg_pkg::FS_STOP;
							txd_r   <= parity_on ? tx_par_r : 1'b1;
						end else begin
							txd_r <= tx_bit;
						end
					end
				end
				usart_cfg_pkg::FS_PARITY: begin
					if (tx_step) begin
						tx_st_r <= usart_cfg_pkg::FS_STOP;
						txd_r   <= 1'b1;
					end
				end
				usart_cfg_pkg::FS_STOP: begin
					if (tx_step)
						tx_st_r <= usart_cfg_pkg::FS_IDLE;
				end
				default: begin
					tx_st_r <= usart_cfg_pkg::FS_IDLE;
					txd_r   <= 1'b1;
				end
			endcase
		end
	end

	//----------------------------------------
	// Receiver
	//----------------------------------------
	usart_cfg_pkg::frame_state_t rx_st_r;
	logic [7:0] rx_sh_r;
	logic [2:0] rx_cnt_r;
	logic [4:0] rx_tick_r;
	logic [1:0] rx_votes_r;
	logic       rx_perr_r;

	wire       in_win   = (rx_tick_r >= win_lo) && (rx_tick_r <= win_hi);
	wire [1:0] vote_sum = rx_votes_r + {1'b0, in_win && rxd};
	wire       rx_step  = sync_async_select ? edge_smp : (rx_tick_r == bit_ticks);
	wire       rx_bit   = sync_async_select ? rxd : vote_sum[1];
	wire [7:0] rx_sh_in = bit_order_select ? {rx_bit, rx_sh_r[7:1]} : {rx_sh_r[6:0], rx_bit};

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			rx_st_r       <= usart_cfg_pkg::FS_IDLE;
			rx_sh_r       <= 8'h00;
			rx_cnt_r      <= 3'h0;
			rx_tick_r     <= 5'h01;
			rx_votes_r    <= 2'h0;
			rx_perr_r     <= 1'b0;
			rx_data       <= 8'h00;
			rx_valid      <= 1'b0;
			rx_parity_err <= 1'b0;
			rx_frame_err  <= 1'b0;
		end else if (!en_l2_r) begin
			rx_st_r  <= usart_cfg_pkg::FS_IDLE;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (rx_st_r == usart_cfg_pkg::FS_IDLE || rx_step) begin
				rx_tick_r  <= 5'h01;
				rx_votes_r <= 2'h0;
			end else begin
				rx_tick_r  <= rx_tick_r + 5'h01;
				rx_votes_r <= vote_sum;
			end
			case (rx_st_r)
				usart_cfg_pkg::FS_IDLE: begin
					if (sync_async_select ? (edge_smp && !rxd) : !rxd) begin
						rx_st_r  <= sync_async_select ? usart_cfg_pkg::FS_DATA : usart_cfg_pkg::FS_START;
						rx_cnt_r <= 3'h0;
					end
				end
				usart_cfg_pkg::FS_START: begin
					if (rx_step) begin
						rx_st_r  <= rx_bit ? usart_cfg_pkg::FS_IDLE : usart_cfg_pkg::FS_DATA;
						rx_cnt_r <= 3'h0;
					end
				end
				usart_cfg_pkg::FS_DATA: begin
					if (rx_step) begin
						rx_sh_r   <= rx_sh_in;
						rx_cnt_r  <= rx_cnt_r + 3'h1;
						rx_perr_r <= 1'b0;
						if (rx_cnt_r == 3'h7)
							rx_st_r <= parity_on ? usart_cfg_pkg::FS_PARITY : usart_cfg_pkg::FS_STOP;
					end
				end
				usart_cfg_pkg::FS_PARITY: begin
					if (rx_step) begin
						rx_perr_r <= rx_bit ^ (^rx_sh_r);
						rx_st_r   <= usart_cfg_pkg::FS_STOP;
					end
				end
				usart_cfg_pkg::FS_STOP: begin
					if (rx_step) begin
						rx_data       <= rx_sh_r;
						rx_valid      <= 1'b1;
						rx_parity_err <= rx_perr_r;
						rx_frame_err  <= !rx_bit;
						rx_st_r       <= usart_cfg_pkg::FS_IDLE;
					end
				end
				default: begin
					rx_st_r <= usart_cfg_pkg::FS_IDLE;
				end
			endcase
		end
	end

	//----------------------------------------
	// Checks
	//----------------------------------------
	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		pready |-> !prdata[`RESERVED_TOP_POS] && !serial_control_first_r[`RESERVED_TOP_POS];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved top bit not zero");

	property p_enable_protect;
		@(posedge pclk) disable iff (!presetn)
		ctrl_wr && enabled_sw && !swrst_wr |=>
			((serial_control_first_r ^ $past(serial_control_first_r)) & `SERIAL_CONTROL_FIRST_EPMASK) == 32'h0;
	endproperty
	a_enable_protect: assert property (p_enable_protect) else $error("protected field changed while enabled");

	property p_guard_blocks;
		@(posedge pclk) disable iff (!presetn)
		xfer_done && pwrite && hit_ctrl && peripheral_write_guard |=> $stable(serial_control_first_r);
	endproperty
	a_guard_blocks: assert property (p_guard_blocks) else $error("guarded write changed control");

	property p_byte_lane;
		@(posedge pclk) disable iff (!presetn)
		ctrl_wr && !swrst_wr && !pstrb[3] |=> serial_control_first_r[31:24] == $past(serial_control_first_r[31:24]);
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("unstrobed byte lane written");

	property p_enable_readback;
		@(posedge pclk) disable iff (!presetn)
		ctrl_wr && !swrst_wr && pstrb[0] |=> enabled_sw == $past(pwdata[`ENABLE_POS]);
	endproperty
	a_enable_readback: assert property (p_enable_readback) else $error("enable not read back at once");

	property p_busy_bounded;
		@(posedge pclk) disable iff (!presetn)
		$changed(enabled_sw) |-> enable_busy ##[1:24] !enable_busy;
	endproperty
	a_busy_bounded: assert property (p_busy_bounded) else $error("enable busy wrong or stuck");

	property p_answer_next;
		@(posedge pclk) disable iff (!presetn)
		access_pend |=> pready ##1 !pready;
	endproperty
	a_answer_next: assert property (p_answer_next) else $error("access not answered in one cycle");

	property p_tick_range;
		@(posedge link_clk) disable iff (!lrst_n)
		en_l2_r && !sync_async_select |-> tx_tick_r < bit_ticks && rx_tick_r <= bit_ticks;
	endproperty
	a_tick_range: assert property (p_tick_range) else $error("tick count beyond bit period");

	property p_pad_route;
		@(posedge link_clk) disable iff (!lrst_n)
		en_l2_r && transmit_pad_select == usart_cfg_pkg::TXPAD_D2_X3 ##1 en_l2_r |->
			pad_oe[2] && !pad_oe[0] && pad_out[2] == $past(txd_r);
	endproperty
	a_pad_route: assert property (p_pad_route) else $error("transmit data not on pad 2");

endmodule : usart_control_a_config

/* File: test/serial_peer.sv */
`timescale 1ns/1ps

//--------
// Serial peer on the pads, link clock domain
//--------
module serial_peer (
	// Link
	input  wire logic       link_clk,
	input  wire logic       line_in,
	output logic            line_out,
	// Frame setup
	input  wire logic [4:0] period,
	input  wire logic       lsb_first,
	input  wire logic       parity_on,
	// Captured frame
	output logic      [7:0] got_data,
	output logic            got_parity,
	output int              got_count
);
	initial begin
		line_out   = 1'b1;
		got_data   = 8'h00;
		got_parity = 1'b0;
		got_count  = 0;
	end

	// Mid-bit sampling of frames from the device
	always begin
		@(negedge line_in);
		repeat (period / 2) @(posedge link_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (period) @(posedge link_clk);
			got_data[lsb_first ? i : 7 - i] = line_in;
		end
		if (parity_on) begin
			repeat (period) @(posedge link_clk);
			got_parity = line_in;
		end
		repeat (period) @(posedge link_clk);
		got_count++;
	end

	task automatic send(input logic [7:0] data);
		@(posedge link_clk);
		line_out <= 1'b0;
		repeat (period) @(posedge link_clk);
		for (int i = 0; i < 8; i++) begin
			line_out <= data[lsb_first ? i : 7 - i];
			repeat (period) @(posedge link_clk);
		end
		if (parity_on) begin
			line_out <= ^data;
			repeat (period) @(posedge link_clk);
		end
		line_out <= 1'b1;
		repeat (period) @(posedge link_clk);
	endtask : send
endmodule : serial_peer

/* File: test/usart_control_a_config_tb_top.sv */
`timescale 1ns/1ps

module usart_control_a_config_tb_top;
	//--------
	// Signals
	//--------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, guard, rerr;
	logic        link_clk, tx_valid, tx_ready, rx_valid, rx_perr, rx_ferr, peer_line, peer_par;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat, cfg;
	logic [3:0]  pstrb, pad_in, pad_out, pad_oe;
	logic [7:0]  tx_data, rx_data, rx_seen, peer_data, d;
	logic [4:0]  per;
	logic [1:0]  tx_idx;
	logic        tx_line;
	int          mismatches, check_count, rx_cnt, peer_count, c0, n;
	logic [67:0] reg_rows [6];
	logic [31:0] link_rows [6];

	// Pads idle high, peer on the receive pad, handshake input held low
	assign pad_in  = (~(4'h1 << cfg[21:20]) | ({3'h0, peer_line} << cfg[21:20])) & ((cfg[17:16] == 2'h2) ? 4'h7 : 4'hF);
	assign tx_line = pad_oe[tx_idx] ? pad_out[tx_idx] : 1'b1;

	usart_control_a_config u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.peripheral_write_guard(guard), .link_clk(link_clk), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_parity_err(rx_perr), .rx_frame_err(rx_ferr));

	serial_peer u_peer (.link_clk(link_clk), .line_in(tx_line), .line_out(peer_line), .period(per),
		.lsb_first(cfg[30]), .parity_on(cfg[24]), .got_data(peer_data), .got_parity(peer_par), .got_count(peer_count));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial begin
		link_clk = 1'b0;
		#1.3;
		forever #6 link_clk = ~link_clk;
	end

	always @(posedge link_clk) if (rx_valid === 1'b1) begin
		rx_seen <= rx_data;
		rx_cnt  <= rx_cnt + 1;
	end

	//--------
	// Tasks
	//--------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
		int k;
		k = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			apb(1'b0, 12'h01C, 32'h0, 4'h0);
			k++;
		end while (rdat[1] !== 1'b0 && k < 30);
	endtask : wait_idle

	task automatic tx_send(input logic [7:0] v);
		int k;
		k = 0;
		@(posedge link_clk);
		tx_valid <= 1'b1;
		tx_data  <= v;
		do begin
			@(posedge link_clk);
			k++;
		end while (tx_ready !== 1'b1 && k < 100);
		tx_valid <= 1'b0;
	endtask : tx_send

	function automatic logic [4:0] per_of(input logic [2:0] r);
		return (r < 3'h2) ? 5'h10 : (r < 3'h4) ? 5'h08 : 5'h03;
	endfunction : per_of

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	//--------
	// Sequence
	//--------
	initial begin
		{presetn, psel, penable, pwrite, guard, tx_valid} = 6'h00;
		{paddr, pwdata, pstrb, tx_data, cfg, rx_seen} = '0;
		{tx_idx, per, mismatches, check_count, rx_cnt} = '0;
		// Data, strobes, readback
		reg_rows = '{{32'h7FFF_FFFC, 4'hF, 32'h7FF3_E09C}, {32'h0000_0000, 4'h1, 32'h7FF3_E000},
			{32'h0000_0000, 4'h2, 32'h7FF3_0000}, {32'h0000_0000, 4'h4, 32'h7F00_0000},
			{32'h7FFF_FFFC, 4'hC, 32'h7FF3_0000}, {32'h7FFF_FFFD, 4'hF, 32'h0000_0000}};
		link_rows = '{32'h00D0_2004, 32'h4031_4000, 32'h0192_8000, 32'h4520_6000, 32'h0401_0000,
			32'h3020_0004};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("reset value", 32'h0000_0000, rdat);
		foreach (reg_rows[i]) begin
			apb(1'b1, 12'h000, reg_rows[i][67:36], reg_rows[i][35:32]);
			apb(1'b0, 12'h000, 32'h0, 4'h0);
			chk("row readback", reg_rows[i][31:0], rdat);
		end
		foreach (link_rows[i]) begin
			cfg = link_rows[i];
			d = 8'h4B ^ 8'(i);
			per = cfg[28] ? 5'h02 : per_of(cfg[15:13]);
			tx_idx = (cfg[17:16] == 2'h1) ? 2'h2 : 2'h0;
			apb(1'b1, 12'h000, cfg, 4'hF);
			apb(1'b1, 12'h000, cfg | 32'h0000_0002, 4'hF);
			wait_idle();
			if (cfg[17:16] == 2'h2) chk("handshake out", 32'h2, {30'h0, pad_oe[2], pad_out[2]});
			c0 = peer_count;
			tx_send(d);
			for (n = 0; peer_count == c0 && n < 600; n++) @(posedge link_clk);
			chk("tx data", {24'h0, d}, {24'h0, peer_data});
			if (cfg[24]) chk("tx parity", {31'h0, ^d}, {31'h0, peer_par});
			c0 = rx_cnt;
			u_peer.send(~d);
			for (n = 0; rx_cnt == c0 && n < 600; n++) @(posedge link_clk);
			chk("rx data", {22'h0, 2'b00, ~d}, {22'h0, rx_perr, rx_ferr, rx_seen});
			apb(1'b1, 12'h000, 32'h0, 4'hF);
			wait_idle();
		end
		apb(1'b1, 12'h000, 32'h0192_8004, 4'hF);
		apb(1'b1, 12'h000, 32'h0192_8006, 4'hF);
		apb(1'b0, 12'h01C, 32'h0, 4'h0);
		chk("enable busy", 32'h2, rdat & 32'h2);
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("enable echo", 32'h0192_8006, rdat);
		wait_idle();
		apb(1'b1, 12'h000, 32'h0000_0002, 4'hF);
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("protected", 32'h0192_8006, rdat);
		apb(1'b1, 12'h000, 32'h0, 4'hF);
		wait_idle();
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("disable", 32'h0192_8004, rdat);
		guard <= 1'b1;
		apb(1'b1, 12'h000, 32'h0, 4'hF);
		chk("guard error", 32'h1, {31'h0, rerr});
		guard <= 1'b0;
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("guarded value", 32'h0192_8004, rdat);
		apb(1'b0, 12'h040, 32'h0, 4'h0);
		chk("unmapped", 32'h1, {rdat[30:0], rerr});
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("pads in reset", 32'h0, {28'h0, pad_oe});
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("value after reset", 32'h0, rdat);
		results();
	end

	initial begin
		#300000;
		mismatches++;
		results();
	end
endmodule : usart_control_a_config_tb_top
